//--- logic/sfp_pkg.sv
/*
 * Constants and types shared by the serial flash protocol front end.
 * Assumes a single-clock register core drives the configuration pulses.
 */
package sfp_pkg;
    // Lane protocols of the serial interface.
    typedef enum logic [1:0] {SFP_EXT, SFP_DUAL, SFP_QUAD} sfp_proto_t;

    // Bit positions in the enhanced volatile and nonvolatile configuration.
    localparam int unsigned EV_DUAL_BIT = 6;
    localparam int unsigned EV_QUAD_BIT = 7;
    localparam int unsigned NV_DUAL_BIT = 2;
    localparam int unsigned NV_QUAD_BIT = 3;

    // Lane counts per clock edge and the bits of one byte.
    localparam logic [3:0] LANE_1 = 4'h1;
    localparam logic [3:0] LANE_2 = 4'h2;
    localparam logic [3:0] LANE_4 = 4'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Width codes for address and data phases of extended commands.
    localparam logic [1:0] EXTW_1 = 2'h0;
    localparam logic [1:0] EXTW_2 = 2'h1;

    // Output enable masks per lane count.
    localparam logic [3:0] OE_1 = 4'h2;
    localparam logic [3:0] OE_2 = 4'h3;
    localparam logic [3:0] OE_4 = 4'hF;

    // Boot counter: the nonvolatile selection is loaded at BOOT_LOAD.
    localparam logic [1:0] BOOT_LOAD = 2'h2;
    localparam logic [1:0] BOOT_DONE = 2'h3;
endpackage

//--- logic/sfp_frontend.sv
/*
 * Serial interface front end of a serial flash: lane protocol selection,
 * bit sampling and driving, byte transfer to the core, frame end check.
 * Assumes the bus master makes SPI_CLK and CS_N, that the core keeps TX_DATA
 * valid for a whole byte after each RX_VALID, and that the core changes the
 * protocol only while the chip is deselected.
 */
module sfp_frontend (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SPI_CLK,
    input wire logic CS_N,
    input wire logic [3:0] SERIAL_LINE_IN,
    output logic [3:0] SERIAL_LINE_OUT,
    output logic [3:0] SERIAL_LINE_OE,
    input wire logic HIGH_VOLTAGE_PIN,
    input wire logic [7:0] NV_CONFIG,
    input wire logic EV_CONFIG_WR,
    input wire logic [7:0] EV_CONFIG_DATA,
    input wire logic RESCUE,
    input wire logic PE_BUSY,
    input wire logic [1:0] EXT_WIDTH,
    input wire logic TX_ENABLE,
    input wire logic [7:0] TX_DATA,
    output logic [7:0] RX_DATA,
    output logic RX_VALID,
    output logic FRAME_END,
    output logic FRAME_WHOLE,
    output logic [1:0] PROTOCOL,
    output logic QUAD_FALLBACK
);
    typedef struct packed {
        sfp_pkg::sfp_proto_t proto;
        sfp_pkg::sfp_proto_t eff;
        sfp_pkg::sfp_proto_t frame;
        logic fb;
        logic [1:0] boot;
        logic [1:0] nv_dual_s;
        logic [1:0] nv_quad_s;
        logic [1:0] hv_s;
        logic [2:0] cs_s;
        logic [2:0] tog_s;
        logic [2:0] ph_s1;
        logic [2:0] ph_s2;
        logic rd_idx;
        logic [7:0] rx;
        logic rx_v;
        logic fend;
        logic fwhole;
    } sfp_sys_t;

    typedef struct packed {
        sfp_pkg::sfp_proto_t proto;
        logic first;
        logic [2:0] ph;
        logic [7:0] sh;
        logic [7:0] slot0;
        logic [7:0] slot1;
        logic tog;
        logic idx;
        logic [1:0] extw_s1;
        logic [1:0] extw_s2;
        logic txen_s1;
        logic txen_s2;
    } sfp_lnk_t;

    typedef struct packed {
        logic [2:0] ph;
        logic [7:0] sh;
        logic [3:0] out;
        logic [3:0] oe;
    } sfp_drv_t;

    sfp_sys_t sys_r, sys_nxt;
    sfp_lnk_t lnk_r, lnk_nxt;
    sfp_drv_t drv_r, drv_nxt;
    logic in_frame_r;
    logic frm_rst_n;

    // Lanes per clock edge; the command byte of extended always uses one.
    function automatic logic [3:0] lanes(input sfp_pkg::sfp_proto_t p, input logic first,
                                         input logic [1:0] extw);
        logic [3:0] w;
        w = sfp_pkg::LANE_1;
        if (p == sfp_pkg::SFP_QUAD) begin
            w = sfp_pkg::LANE_4;
        end else if (p == sfp_pkg::SFP_DUAL) begin
            w = sfp_pkg::LANE_2;
        end else if (first || extw == sfp_pkg::EXTW_1) begin
            w = sfp_pkg::LANE_1;
        end else if (extw == sfp_pkg::EXTW_2) begin
            w = sfp_pkg::LANE_2;
        end else begin
            w = sfp_pkg::LANE_4;
        end
        return w;
    endfunction

    // Deselect releases the drivers and rearms frame start at once.
    assign frm_rst_n = RESET_N & ~CS_N;

    // Core clock side: protocol selection, crossings and byte hand-over.
    always_comb begin
        sys_nxt = sys_r;
        sys_nxt.nv_dual_s = {sys_r.nv_dual_s[0], NV_CONFIG[sfp_pkg::NV_DUAL_BIT]};
        sys_nxt.nv_quad_s = {sys_r.nv_quad_s[0], NV_CONFIG[sfp_pkg::NV_QUAD_BIT]};
        sys_nxt.hv_s = {sys_r.hv_s[0], HIGH_VOLTAGE_PIN};
        sys_nxt.cs_s = {sys_r.cs_s[1:0], CS_N};
        sys_nxt.tog_s = {sys_r.tog_s[1:0], lnk_r.tog};
        sys_nxt.ph_s1 = lnk_r.ph;
        sys_nxt.ph_s2 = sys_r.ph_s1;
        if (sys_r.boot != sfp_pkg::BOOT_DONE) begin
            sys_nxt.boot = sys_r.boot + 2'h1;
        end
        // Power-on takes the nonvolatile choice and drops any volatile one.
        if (sys_r.boot == sfp_pkg::BOOT_LOAD) begin
            if (!sys_r.nv_quad_s[1]) begin
                sys_nxt.proto = sfp_pkg::SFP_QUAD;
            end else if (!sys_r.nv_dual_s[1]) begin
                sys_nxt.proto = sfp_pkg::SFP_DUAL;
            end else begin
                sys_nxt.proto = sfp_pkg::SFP_EXT;
            end
        end else if (RESCUE) begin
            sys_nxt.proto = sfp_pkg::SFP_EXT;
        end else if (EV_CONFIG_WR) begin
            if (!EV_CONFIG_DATA[sfp_pkg::EV_QUAD_BIT]) begin
                sys_nxt.proto = sfp_pkg::SFP_QUAD;
            end else if (!EV_CONFIG_DATA[sfp_pkg::EV_DUAL_BIT]) begin
                sys_nxt.proto = sfp_pkg::SFP_DUAL;
            end else begin
                sys_nxt.proto = sfp_pkg::SFP_EXT;
            end
        end
        // High-voltage program or erase drops quad to extended until the pin falls or PE_BUSY clears.
        sys_nxt.fb = sys_r.proto == sfp_pkg::SFP_QUAD && sys_r.hv_s[1] && PE_BUSY;
        sys_nxt.eff = sys_nxt.fb ? sfp_pkg::SFP_EXT : sys_r.proto;
        // The frame protocol is frozen while the chip is selected.
        if (sys_r.cs_s[1]) begin
            sys_nxt.frame = sys_nxt.eff;
        end
        sys_nxt.rx_v = sys_r.tog_s[1] ^ sys_r.tog_s[2];
        if (sys_nxt.rx_v) begin
            sys_nxt.rx = sys_r.rd_idx ? lnk_r.slot1 : lnk_r.slot0;
            sys_nxt.rd_idx = ~sys_r.rd_idx;
        end
        // Rising chip select closes the frame and checks for whole bytes.
        sys_nxt.fend = sys_r.cs_s[1] & ~sys_r.cs_s[2];
        if (sys_nxt.fend) begin
            sys_nxt.fwhole = sys_r.ph_s2 == 3'h0;
        end
    end

    // Core clock register.
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sys_r <= '0;
            sys_r.cs_s <= 3'h7;
        end else begin
            sys_r <= sys_nxt;
        end
    end

    // Frame start marker, cleared by the deselect itself.
    always_ff @(posedge SPI_CLK or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            in_frame_r <= 1'b0;
        end else begin
            in_frame_r <= 1'b1;
        end
    end

    // Link side: sample lanes on the rising edge, mode-agnostic by design.
    always_comb begin
        sfp_pkg::sfp_proto_t p;
        logic first;
        logic [3:0] w;
        logic [3:0] sum;
        logic [7:0] sh;
        sh = lnk_r.sh;
        lnk_nxt = lnk_r;
        lnk_nxt.extw_s1 = EXT_WIDTH;
        lnk_nxt.extw_s2 = lnk_r.extw_s1;
        lnk_nxt.txen_s1 = TX_ENABLE;
        lnk_nxt.txen_s2 = lnk_r.txen_s1;
        p = in_frame_r ? lnk_r.proto : sys_r.frame;
        first = in_frame_r ? lnk_r.first : 1'b1;
        w = lanes(p, first, lnk_r.extw_s2);
        sum = {1'b0, (in_frame_r ? lnk_r.ph : 3'h0)} + w;
        case (w)
            sfp_pkg::LANE_1: sh = {lnk_r.sh[6:0], SERIAL_LINE_IN[0]};
            sfp_pkg::LANE_2: sh = {lnk_r.sh[5:0], SERIAL_LINE_IN[1:0]};
            default: sh = {lnk_r.sh[3:0], SERIAL_LINE_IN};
        endcase
        lnk_nxt.proto = p;
        lnk_nxt.first = first;
        lnk_nxt.sh = sh;
        lnk_nxt.ph = sum[2:0];
        if (sum == sfp_pkg::BYTE_BITS) begin
            if (lnk_r.idx) begin
                lnk_nxt.slot1 = sh;
            end else begin
                lnk_nxt.slot0 = sh;
            end
            lnk_nxt.idx = ~lnk_r.idx;
            lnk_nxt.tog = ~lnk_r.tog;
            lnk_nxt.first = 1'b0;
        end
    end

    // Link rising-edge register; the same logic serves both clock modes.
    always_ff @(posedge SPI_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lnk_r <= '0;
        end else begin
            lnk_r <= lnk_nxt;
        end
    end

    // Link falling edge: a byte starts only on a received byte boundary, so both modes align.
    always_comb begin
        logic [3:0] dw;
        logic [7:0] cur;
        logic [3:0] sum;
        drv_nxt = drv_r;
        dw = lanes(lnk_r.proto, 1'b0, lnk_r.extw_s2);
        cur = drv_r.ph == 3'h0 ? TX_DATA : drv_r.sh;
        sum = {1'b0, drv_r.ph} + dw;
        if (lnk_r.txen_s2 && (drv_r.ph != 3'h0 || (in_frame_r && lnk_r.ph == 3'h0))) begin
            drv_nxt.sh = cur << dw;
            drv_nxt.ph = sum[2:0];
            case (dw)
                sfp_pkg::LANE_1: begin
                    drv_nxt.out = {2'h0, cur[7], 1'b0};
                    drv_nxt.oe = sfp_pkg::OE_1;
                end
                sfp_pkg::LANE_2: begin
                    drv_nxt.out = {2'h0, cur[7:6]};
                    drv_nxt.oe = sfp_pkg::OE_2;
                end
                default: begin
                    drv_nxt.out = cur[7:4];
                    drv_nxt.oe = sfp_pkg::OE_4;
                end
            endcase
        end else begin
            drv_nxt.ph = 3'h0;
            drv_nxt.oe = 4'h0;
        end
    end

    // Falling-edge register, released while deselected or in reset.
    always_ff @(negedge SPI_CLK or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            drv_r <= '0;
        end else begin
            drv_r <= drv_nxt;
        end
    end

    // Outputs straight from registers.
    assign SERIAL_LINE_OUT = drv_r.out;
    assign SERIAL_LINE_OE = drv_r.oe;
    assign RX_DATA = sys_r.rx;
    assign RX_VALID = sys_r.rx_v;
    assign FRAME_END = sys_r.fend;
    assign FRAME_WHOLE = sys_r.fwhole;
    assign PROTOCOL = sys_r.eff;
    assign QUAD_FALLBACK = sys_r.fb;

    // Frame close is one cycle of synchronised rising chip select.
    sequence frame_close_s;
        sys_r.cs_s[1] && !sys_r.cs_s[2];
    endsequence

    sequence end_pulse_s;
        FRAME_END ##1 !FRAME_END;
    endsequence

    a_boot_quad: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.boot == sfp_pkg::BOOT_LOAD && !sys_r.nv_quad_s[1] |=> ##1 PROTOCOL == sfp_pkg::SFP_QUAD || QUAD_FALLBACK)
        else $error("nonvolatile quad not taken at power-on");
    a_boot_dual: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.boot == sfp_pkg::BOOT_LOAD && sys_r.nv_quad_s[1] && !sys_r.nv_dual_s[1]
        |=> sys_r.proto == sfp_pkg::SFP_DUAL)
        else $error("nonvolatile dual not taken at power-on");
    a_ev_quad: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.boot == sfp_pkg::BOOT_DONE && !RESCUE && EV_CONFIG_WR && !EV_CONFIG_DATA[7]
        |=> sys_r.proto == sfp_pkg::SFP_QUAD)
        else $error("volatile quad write ignored");
    a_ev_dual: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.boot == sfp_pkg::BOOT_DONE && !RESCUE && EV_CONFIG_WR && EV_CONFIG_DATA[7:6] == 2'h2
        |=> ##1 PROTOCOL == sfp_pkg::SFP_DUAL)
        else $error("volatile dual write ignored");
    a_rescue_ext: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.boot == sfp_pkg::BOOT_DONE && RESCUE |=> ##1 PROTOCOL == sfp_pkg::SFP_EXT)
        else $error("rescue did not restore extended");
    a_hv_fallback: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.proto == sfp_pkg::SFP_QUAD && sys_r.hv_s[1] && PE_BUSY
        |=> QUAD_FALLBACK && PROTOCOL == sfp_pkg::SFP_EXT)
        else $error("no extended fallback under high voltage");
    a_quad_resume: assert property (@(posedge CLK) disable iff (!RESET_N)
        sys_r.proto == sfp_pkg::SFP_QUAD && !sys_r.hv_s[1] && $past(sys_r.proto) == sfp_pkg::SFP_QUAD
        |=> PROTOCOL == sfp_pkg::SFP_QUAD)
        else $error("quad not resumed after high voltage");
    a_idle_release: assert property (@(posedge CLK) disable iff (!RESET_N)
        CS_N |-> SERIAL_LINE_OE == 4'h0)
        else $error("lines driven while deselected");
    a_frame_whole: assert property (@(posedge CLK) disable iff (!RESET_N)
        frame_close_s |=> end_pulse_s and (FRAME_WHOLE == ($past(sys_r.ph_s2) == 3'h0)))
        else $error("frame end check wrong");
    a_cmd_single: assert property (@(posedge SPI_CLK) disable iff (!RESET_N)
        !in_frame_r && sys_r.frame == sfp_pkg::SFP_EXT && !CS_N |=> lnk_r.ph == 3'h1)
        else $error("command bit not on one line");
    a_quad_lanes: assert property (@(posedge SPI_CLK) disable iff (!RESET_N)
        !in_frame_r && sys_r.frame == sfp_pkg::SFP_QUAD && !CS_N |=> lnk_r.ph == 3'h4)
        else $error("quad frame not on four lines");
endmodule

//--- verif/sfp_master.sv
/* Bus master model: makes the serial clock, chip select and input lanes.
   Assumes the bench calls one task at a time and waits between frames. */
module sfp_master (
    output logic spi_clk,
    output logic cs_n,
    output wire logic [3:0] line_in,
    input wire logic [3:0] line_out,
    input wire logic [3:0] line_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] drv;
    logic cpol;
    // A lane shows the device while it drives, else the master's level.
    assign line_in = (line_oe & line_out) | (~line_oe & drv);
    // Idle bus: deselected, clock still, lanes at defined levels.
    initial begin
        spi_clk = 1'b0;
        cs_n = 1'b1;
        drv = 4'hA;
    end
    // Parks the clock at the mode's idle level, then selects.
    task automatic open_frame(input logic pol);
        cpol = pol;
        spi_clk = pol;
        #20 cs_n = 1'b0;
    endtask
    // Data changes with the clock low; both sides sample on the rise.
    task automatic clocks(input logic [7:0] tx, input int lanes, input int steps, output logic [7:0] rx);
        rx = 8'h00;
        for (int k = 0; k < steps; k++) begin
            spi_clk = 1'b0;
            drv = ~drv;
            for (int j = 0; j < lanes; j++) begin
                drv[lanes - 1 - j] = tx[7 - j];
            end
            tx = tx << lanes;
            #16 spi_clk = 1'b1;
            for (int j = 0; j < lanes; j++) begin
                rx = {rx[6:0], line_in[lanes == 1 ? 1 : lanes - 1 - j]};
            end
            #16;
        end
    endtask
    // Returns the clock to idle and deselects; unused lanes keep moving.
    task automatic close_frame();
        #16 spi_clk = cpol;
        #4 cs_n = 1'b1;
        drv = ~drv;
    endtask
    // Toggles the clock while deselected, which the device must ignore.
    task automatic stray(input int n);
        repeat (n) begin
            #16 spi_clk = ~spi_clk;
        end
    endtask
endmodule

//--- verif/sfp_frontend_tb.sv
/* Self-checking bench for the serial flash front end.
   Assumes the master model of sfp_master.sv on the link side. */
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
`define WAITC(cond) begin for (int w = 0; w < 40 && !((cond) === 1'b1); w++) tick(1); \
    if (!((cond) === 1'b1)) begin errors++; give_verdict(); end end
module sfp_frontend_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, hv, ev_wr, rescue, pe_busy, tx_en, spi_clk, cs_n;
    logic rx_valid, frame_end, whole, fallback, last_whole;
    logic [7:0] nv, ev_data, tx_data, rx_data;
    logic [1:0] ext_w, proto;
    logic [3:0] line_in, line_out, line_oe;
    int errors, samples_checked, frames;
    logic [7:0] rxq[$];
    sfp_master i_master (.spi_clk(spi_clk), .cs_n(cs_n), .line_in(line_in), .line_out(line_out), .line_oe(line_oe));
    sfp_frontend i_dut (.CLK(clk), .RESET_N(reset_n), .SPI_CLK(spi_clk), .CS_N(cs_n), .SERIAL_LINE_IN(line_in),
        .SERIAL_LINE_OUT(line_out), .SERIAL_LINE_OE(line_oe), .HIGH_VOLTAGE_PIN(hv), .NV_CONFIG(nv),
        .EV_CONFIG_WR(ev_wr), .EV_CONFIG_DATA(ev_data), .RESCUE(rescue), .PE_BUSY(pe_busy), .EXT_WIDTH(ext_w),
        .TX_ENABLE(tx_en), .TX_DATA(tx_data), .RX_DATA(rx_data), .RX_VALID(rx_valid), .FRAME_END(frame_end),
        .FRAME_WHOLE(whole), .PROTOCOL(proto), .QUAD_FALLBACK(fallback));
    // Core clock, 25 ns period.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Collects received bytes and frame-end results.
    always @(posedge clk) begin
        if (rx_valid === 1'b1) rxq.push_back(rx_data);
        if (frame_end === 1'b1) begin
            last_whole = whole;
            frames++;
        end
    end
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Waits edges, then steps off the edge before driving.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic do_reset(input logic [7:0] v);
        reset_n = 1'b0;
        nv = v;
        tick(16);
        reset_n = 1'b1;
        tick(6);
    endtask
    // One configuration pulse; the protocol is due two edges later.
    task automatic cfg(input logic [7:0] d, input logic r);
        ev_data = d;
        ev_wr = 1'b1;
        rescue = r;
        tick(1);
        ev_wr = 1'b0;
        rescue = 1'b0;
        tick(2);
    endtask
    // Two-byte frame; the second byte may be cut short.
    task automatic frame(input logic pol, input int l0, l1, input logic [7:0] b0, b1, input int steps,
            output logic [7:0] r);
        int f;
        logic [7:0] r0;
        f = frames;
        rxq.delete();
        i_master.open_frame(pol);
        i_master.clocks(b0, l0, 8 / l0, r0);
        i_master.clocks(b1, l1, steps, r);
        i_master.close_frame();
        `WAITC(frames != f)
        tick(2);
        `CHK(line_oe, 4'h0)
    endtask
    task automatic t_boot();
        logic [7:0] nvs[4] = '{8'hFF, 8'hFB, 8'hF7, 8'hF3};
        logic [1:0] exp[4] = '{2'h0, 2'h1, 2'h2, 2'h2};
        for (int i = 0; i < 4; i++) begin
            cfg(8'h7F, 1'b0);
            do_reset(nvs[i]);
            `CHK(proto, exp[i])
            do_reset(nvs[i]);
            `CHK(proto, exp[i])
        end
        do_reset(8'hFF);
        $display("test boot done");
    endtask
    task automatic t_modes();
        logic [7:0] evs[3] = '{8'hFF, 8'hBF, 8'h7F};
        int ln[3] = '{1, 2, 4};
        logic [7:0] r;
        int l1;
        for (int p = 0; p < 3; p++) begin
            for (int pol = 0; pol < 2; pol++) begin
                cfg(evs[p], 1'b0);
                ext_w = 2'(pol);
                // The second byte takes as many steps as its lane count allows, one byte exactly.
                l1 = p == 0 ? 1 + pol : ln[p];
                `CHK(proto, 2'(p))
                frame(pol[0], ln[p], l1, 8'hC3, 8'h5A ^ 8'(p), 8 / l1, r);
                `CHK(rxq.size(), 2)
                `CHK(rxq[0], 8'hC3)
                `CHK(rxq[1], 8'h5A ^ 8'(p))
                `CHK(last_whole, 1'b1)
            end
        end
        $display("test modes done");
    endtask
    task automatic t_tx();
        logic [7:0] r;
        cfg(8'hFF, 1'b0);
        ext_w = 2'h0;
        tx_data = 8'hA5;
        tx_en = 1'b1;
        for (int pol = 0; pol < 2; pol++) begin
            frame(pol[0], 1, 1, 8'h0B, 8'h00, 8, r);
            `CHK(r, 8'hA5)
        end
        tx_en = 1'b0;
        $display("test transmit done");
    endtask
    task automatic t_rescue_fallback();
        logic [7:0] r;
        cfg(8'h7F, 1'b0);
        cfg(8'hBF, 1'b1);
        `CHK(proto, sfp_pkg::SFP_EXT)
        cfg(8'h7F, 1'b0);
        pe_busy = 1'b1;
        hv = 1'b1;
        `WAITC(fallback)
        `CHK(proto, sfp_pkg::SFP_EXT)
        frame(1'b0, 1, 1, 8'h05, 8'h70, 8, r);
        `CHK(rxq[1], 8'h70)
        hv = 1'b0;
        `WAITC(!fallback)
        `CHK(proto, sfp_pkg::SFP_QUAD)
        pe_busy = 1'b0;
        $display("test rescue and fallback done");
    endtask
    task automatic t_partial();
        logic [7:0] r;
        cfg(8'hFF, 1'b0);
        frame(1'b0, 1, 1, 8'h9C, 8'hFF, 4, r);
        `CHK(rxq.size(), 1)
        `CHK(last_whole, 1'b0)
        i_master.stray(8);
        tick(8);
        `CHK(rxq.size(), 1)
        frame(1'b0, 1, 1, 8'h81, 8'h18, 8, r);
        `CHK(rxq[0], 8'h81)
        $display("test partial done");
    endtask
    // Main sequence: drive every input at time zero, reset, run tests.
    initial begin
        reset_n = 1'b0;
        nv = 8'hFF;
        hv = 1'b0;
        ev_wr = 1'b0;
        ev_data = 8'hFF;
        rescue = 1'b0;
        pe_busy = 1'b0;
        tx_en = 1'b0;
        tx_data = 8'h00;
        ext_w = 2'h0;
        errors = 0;
        samples_checked = 0;
        frames = 0;
        tick(16);
        reset_n = 1'b1;
        tick(6);
        `CHK(proto, sfp_pkg::SFP_EXT)
        t_boot();
        t_modes();
        t_tx();
        t_rescue_fallback();
        t_partial();
        give_verdict();
    end
endmodule
